// [rtl/scr_cfg.svh]
// scr_cfg.svh - offsets, field positions, reset values and timing figures of the supervisor config bank
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

// register offsets on the serial management interface
`define SCR_OFF_ON_HOLD     8'h09
`define SCR_OFF_OFF_DELAY   8'h0A
`define SCR_OFF_RS_HOLD     8'h0B
`define SCR_OFF_WD_PERIOD   8'h0C
`define SCR_OFF_RST_CFG     8'h0D
`define SCR_OFF_RAIL_SEL    8'h0E
`define SCR_OFF_WD_MODE     8'h0F
`define SCR_OFF_LOCK        8'h15

// field positions
`define SCR_CODE_MSB        2
`define SCR_RST_CFG_MSB     3
`define SCR_RST_NO_SHUTDOWN_OUT_N_BIT 0
`define SCR_RST_POL_BIT     1
`define SCR_RST_NO_UV4_BIT  2
`define SCR_RST_FLOAT_BIT   3
`define SCR_RAIL_SEL_BIT    3
`define SCR_WD_MODE_BIT     3

// reset and read-back values
`define SCR_REG_RESET       8'h00
`define SCR_LOCK_READ       8'h01
`define SCR_UNMAPPED_READ   8'h00

// times selected by timing code zero, in ms
`define SCR_ON_HOLD_MS      10
`define SCR_OFF_DELAY_MS    100
`define SCR_RS_HOLD_MS      200
`define SCR_WD_PERIOD_MS    1500

// default 7-bit serial slave address; arbitrary value
`define SCR_DEV_ADDR        7'h2C

`endif

// [rtl/scr_pkg.sv]
// scr_pkg.sv - types shared by the supervisor config bank
package scr_pkg;

  // serial slave protocol states
  typedef enum logic [3:0] {
    SCR_IDLE,
    SCR_ADDR,
    SCR_ADDR_ACK,
    SCR_PTR,
    SCR_PTR_ACK,
    SCR_WDATA,
    SCR_WDATA_ACK,
    SCR_RDATA,
    SCR_RDATA_ACK
  } scr_i2c_state_t;

  // configuration held by the bank, fed to the supervisor logic
  typedef struct packed {
    logic [2:0] turn_on_hold_time;     // shutdown hold code
    logic [2:0] turn_off_delay_time;   // shutdown delay code
    logic [2:0] reset_hold_time;       // reset hold code
    logic [2:0] watchdog_period;       // watchdog timeout code
    logic [3:0] reset_cfg;             // reset behaviour options
    logic       rail_internal_regulator_rail;             // shutdown rail on regulator
    logic       wd_advanced;           // watchdog advanced mode
    logic       locked;                // programming lock
  } scr_regs_t;

  // reset causes from the surrounding supervisor
  typedef struct packed {
    logic other_cause;      // manual, threshold or watchdog cause
    logic shutdown_active;  // shutdown output is asserted
    logic fourth_under;     // fourth monitor under threshold
    logic kick_floating;    // watchdog kick input seen floating
  } scr_causes_t;

  // synchroniser state
  typedef struct packed {
    logic [1:0] meta;    // first stage
    logic [1:0] stable;  // second stage
  } scr_sync_t;

  // whole state of the bank
  typedef struct packed {
    scr_i2c_state_t state;
    logic [3:0]     bit_cnt;
    logic [7:0]     shift;
    logic           rw;
    logic [7:0]     ptr;
    logic           master_ack;
    logic           sda_oe;
    logic           sda_out;
    logic           scl_q;
    logic           sda_q;
    scr_regs_t      regs;
    logic           reset_out;
  } scr_state_t;

endpackage

// [rtl/scr_sync.sv]
// scr_sync.sv - two-flop synchroniser for the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none

module scr_sync
  import scr_pkg::*;
(
  input  wire logic       clock,   // system clock
  input  wire logic       rst_b,   // async reset, active low
  input  wire logic [1:0] pin_in,  // raw pins: {scl, sda}
  output logic      [1:0] pin_out  // synchronised pins
);

  scr_sync_t st_ff;   // both stages
  scr_sync_t nxt_st;  // next stages

  // first stage feeds only the second stage
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.meta   = pin_in;
    nxt_st.stable = st_ff.meta;
  end

  // idle bus is high, so reset to ones to avoid a false start
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{meta: 2'h3, stable: 2'h3};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_out = st_ff.stable;

endmodule

`default_nettype wire

// [rtl/scr_regs.sv]
// scr_regs.sv - supervisor configuration bank behind a serial management slave
`timescale 1ns/1ps
`default_nettype none
`include "scr_cfg.svh"

module scr_regs
  import scr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `SCR_DEV_ADDR  // serial slave address
)
(
  input  wire logic                clock,       // 125 MHz system clock
  input  wire logic                rst_b,       // power-on reset, active low
  input  wire logic                scl_in,      // serial clock pin level
  input  wire logic                sda_in,      // serial data pin level
  output logic                     sda_out,     // serial data drive value
  output logic                     sda_oe,      // serial data drive enable
  input  wire scr_pkg::scr_causes_t causes,     // reset causes, same clock
  output scr_pkg::scr_regs_t       cfg_out,     // configuration to supervisor
  output logic                     reset_out    // reset pin level
);

  scr_state_t st_ff;   // all state
  scr_state_t nxt_st;  // next state
  logic [1:0] pins_s;  // synchronised {scl, sda}
  logic       scl_s;   // synchronised clock
  logic       sda_s;   // synchronised data
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       rst_assert;

  // pins come from the host's domain
  scr_sync u_sync (
    .clock   (clock),
    .rst_b   (rst_b),
    .pin_in  ({scl_in, sda_in}),
    .pin_out (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // register read mux, reserved bits and unmapped offsets read zero
  function automatic logic [7:0] read_reg(input scr_regs_t r, input logic [7:0] a);
    logic [7:0] d;
    d = `SCR_UNMAPPED_READ;
    if (a == `SCR_OFF_ON_HOLD) begin
      d = {5'h00, r.turn_on_hold_time};
    end else if (a == `SCR_OFF_OFF_DELAY) begin
      d = {5'h00, r.turn_off_delay_time};
    end else if (a == `SCR_OFF_RS_HOLD) begin
      d = {5'h00, r.reset_hold_time};
    end else if (a == `SCR_OFF_WD_PERIOD) begin
      d = {5'h00, r.watchdog_period};
    end else if (a == `SCR_OFF_RST_CFG) begin
      d = {4'h0, r.reset_cfg};
    end else if (a == `SCR_OFF_RAIL_SEL) begin
      d = {4'h0, r.rail_internal_regulator_rail, 3'h0};
    end else if (a == `SCR_OFF_WD_MODE) begin
      d = {4'h0, r.wd_advanced, 3'h0};
    end else if (a == `SCR_OFF_LOCK) begin
      d = r.locked ? `SCR_LOCK_READ : `SCR_REG_RESET;
    end
    return d;
  endfunction

  // register write, dropped once the bank is locked
  function automatic scr_regs_t write_reg(input scr_regs_t r, input logic [7:0] a, input logic [7:0] d);
    scr_regs_t n;
    n = r;
    if (r.locked) begin
      n = r;
    end else if (a == `SCR_OFF_ON_HOLD) begin
      n.turn_on_hold_time = d[`SCR_CODE_MSB:0];
    end else if (a == `SCR_OFF_OFF_DELAY) begin
      n.turn_off_delay_time = d[`SCR_CODE_MSB:0];
    end else if (a == `SCR_OFF_RS_HOLD) begin
      n.reset_hold_time = d[`SCR_CODE_MSB:0];
    end else if (a == `SCR_OFF_WD_PERIOD) begin
      n.watchdog_period = d[`SCR_CODE_MSB:0];
    end else if (a == `SCR_OFF_RST_CFG) begin
      n.reset_cfg = d[`SCR_RST_CFG_MSB:0];
    end else if (a == `SCR_OFF_RAIL_SEL) begin
      n.rail_internal_regulator_rail = d[`SCR_RAIL_SEL_BIT];
    end else if (a == `SCR_OFF_WD_MODE) begin
      n.wd_advanced = d[`SCR_WD_MODE_BIT];
    end else if (a == `SCR_OFF_LOCK) begin
      n.locked = 1'b1;  // any write locks; only reset unlocks
    end
    return n;
  endfunction

  // bus conditions from synchronised pins and their previous values
  always_comb begin
    scl_rise = scl_s & ~st_ff.scl_q;
    scl_fall = ~scl_s & st_ff.scl_q;
    start_c  = st_ff.scl_q & scl_s & st_ff.sda_q & ~sda_s;
    stop_c   = st_ff.scl_q & scl_s & ~st_ff.sda_q & sda_s;
  end

  // reset pin: combine causes under the configured options
  always_comb begin
    rst_assert = causes.other_cause
               | (causes.shutdown_active & ~st_ff.regs.reset_cfg[`SCR_RST_NO_SHUTDOWN_OUT_N_BIT])
               | (causes.fourth_under & ~st_ff.regs.reset_cfg[`SCR_RST_NO_UV4_BIT])
               | (causes.kick_floating & st_ff.regs.reset_cfg[`SCR_RST_FLOAT_BIT]);
  end

  // serial slave and register update
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.scl_q   = scl_s;
    nxt_st.sda_q   = sda_s;
    nxt_st.sda_out = 1'b0;  // open drain: only ever pulls low
    // polarity flip; bit1 one means high when asserted
    nxt_st.reset_out = st_ff.regs.reset_cfg[`SCR_RST_POL_BIT] ? rst_assert : ~rst_assert;
    if (start_c) begin
      // start or repeated start always restarts the address phase
      nxt_st.state   = SCR_ADDR;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.sda_oe  = 1'b0;
    end else if (stop_c) begin
      nxt_st.state  = SCR_IDLE;
      nxt_st.sda_oe = 1'b0;
    end else begin
      case (st_ff.state)
        SCR_ADDR, SCR_PTR, SCR_WDATA: begin
          if (scl_rise) begin
            // data is sampled while the clock rises
            nxt_st.shift   = {st_ff.shift[6:0], sda_s};
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          end else if (scl_fall && st_ff.bit_cnt == 4'h8) begin
            nxt_st.bit_cnt = 4'h0;
            nxt_st.sda_oe  = 1'b1;  // acknowledge the byte
            if (st_ff.state == SCR_ADDR) begin
              if (st_ff.shift[7:1] == DEV_ADDR) begin
                nxt_st.rw    = st_ff.shift[0];
                nxt_st.state = SCR_ADDR_ACK;
              end else begin
                // not ours: stay silent until the next start
                nxt_st.sda_oe = 1'b0;
                nxt_st.state  = SCR_IDLE;
              end
            end else if (st_ff.state == SCR_PTR) begin
              nxt_st.ptr   = st_ff.shift;
              nxt_st.state = SCR_PTR_ACK;
            end else begin
              nxt_st.regs  = write_reg(st_ff.regs, st_ff.ptr, st_ff.shift);
              nxt_st.ptr   = st_ff.ptr + 8'h01;
              nxt_st.state = SCR_WDATA_ACK;
            end
          end
        end
        SCR_ADDR_ACK, SCR_PTR_ACK, SCR_WDATA_ACK: begin
          if (scl_fall) begin
            nxt_st.sda_oe = 1'b0;
            if (st_ff.state == SCR_ADDR_ACK && st_ff.rw) begin
              // read from the current pointer, first bit out now
              nxt_st.shift  = read_reg(st_ff.regs, st_ff.ptr);
              nxt_st.ptr    = st_ff.ptr + 8'h01;
              nxt_st.sda_oe = ~nxt_st.shift[7];
              nxt_st.state  = SCR_RDATA;
            end else if (st_ff.state == SCR_ADDR_ACK) begin
              nxt_st.state = SCR_PTR;
            end else begin
              nxt_st.state = SCR_WDATA;
            end
          end
        end
        SCR_RDATA: begin
          if (scl_fall) begin
            if (st_ff.bit_cnt == 4'h7) begin
              // release the line for the host's acknowledge
              nxt_st.bit_cnt = 4'h0;
              nxt_st.sda_oe  = 1'b0;
              nxt_st.state   = SCR_RDATA_ACK;
            end else begin
              nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
              nxt_st.shift   = {st_ff.shift[6:0], 1'b0};
              nxt_st.sda_oe  = ~st_ff.shift[6];
            end
          end
        end
        SCR_RDATA_ACK: begin
          if (scl_rise) begin
            nxt_st.master_ack = ~sda_s;
          end else if (scl_fall) begin
            if (st_ff.master_ack) begin
              // host wants more: auto-increment read
              nxt_st.shift  = read_reg(st_ff.regs, st_ff.ptr);
              nxt_st.ptr    = st_ff.ptr + 8'h01;
              nxt_st.sda_oe = ~nxt_st.shift[7];
              nxt_st.state  = SCR_RDATA;
            end else begin
              nxt_st.state = SCR_IDLE;
            end
          end
        end
        default: begin
          nxt_st.sda_oe = 1'b0;  // idle waits for a start
        end
      endcase
    end
  end

  // all registers clear at power-on; reset pin starts asserted low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff            <= '0;
      st_ff.state      <= SCR_IDLE;
      st_ff.scl_q      <= 1'b1;
      st_ff.sda_q      <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sda_out   = st_ff.sda_out;
  assign sda_oe    = st_ff.sda_oe;
  assign cfg_out   = st_ff.regs;
  assign reset_out = st_ff.reset_out;

endmodule

`default_nettype wire

// [sim/scr_host.sv]
// scr_host.sv - serial host model that drives the management bus of the config bank
`timescale 1ns/1ps
`default_nettype none

module scr_host (
  input  wire logic clock,     // system clock paces every bus phase
  input  wire logic sda_line,  // resolved data wire
  output logic      scl,       // serial clock, host only
  output logic      sda_pull   // high pulls data low
);
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // move only on falling edges so the bank samples settled pins
  task automatic gap(input int n);
    repeat (n) @(negedge clock);
  endtask

  // one bit: 8 clocks low, 8 high, read late in the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_pull = ~b;
    gap(4);
    scl = 1'b1;
    gap(8);
    s   = sda_line;
    scl = 1'b0;
    gap(4);
  endtask

  // byte msb first, then the ninth bit (ack sent or seen)
  task automatic byte_io(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic sack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(mack, sack);
  endtask

  // start or repeated start: data falls while clock is high
  task automatic start;
    sda_pull = 1'b0;
    gap(4);
    scl = 1'b1;
    gap(8);
    sda_pull = 1'b1;
    gap(8);
    scl = 1'b0;
    gap(4);
  endtask

  // stop: data rises while clock is high, bus left idle
  task automatic stop;
    sda_pull = 1'b1;
    gap(4);
    scl = 1'b1;
    gap(8);
    sda_pull = 1'b0;
    gap(8);
  endtask
endmodule
`default_nettype wire

// [sim/scr_regs_checker.sv]
// scr_regs_checker.sv - port assertions for the supervisor config bank
`timescale 1ns/1ps
`default_nettype none

module scr_regs_checker (
  input wire logic                 clock,
  input wire logic                 rst_b,
  input wire logic                 scl_in,
  input wire logic                 sda_in,
  input wire logic                 sda_out,
  input wire logic                 sda_oe,
  input wire scr_pkg::scr_causes_t causes,
  input wire scr_pkg::scr_regs_t   cfg_out,
  input wire logic                 reset_out
);
  import scr_pkg::*;

  logic        valid;  // previous edge was out of reset
  scr_causes_t pcs;    // causes one cycle back
  scr_regs_t   pcfg;   // configuration one cycle back

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // one-cycle history, so values held in reset are never compared
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      valid <= 1'b0;
      pcs   <= '0;
      pcfg  <= '0;
    end else begin
      valid <= 1'b1;
      pcs   <= causes;
      pcfg  <= cfg_out;
    end
  end

  a_idle_level: assert property (valid && pcs == 4'h0 |-> reset_out == ~pcfg.reset_cfg[1])
    else $error("reset pin wrong with no cause");
  a_shutdown_out_n_couple: assert property (valid && pcs == 4'h4 |-> reset_out == (pcfg.reset_cfg[0] ^ pcfg.reset_cfg[1]))
    else $error("reset pin wrong on shutdown");
  a_fourth_mask: assert property (valid && pcs == 4'h2 |-> reset_out == (pcfg.reset_cfg[2] ^ pcfg.reset_cfg[1]))
    else $error("reset pin wrong on fourth monitor");
  a_kick_float: assert property (valid && pcs == 4'h1 |-> reset_out == ~(pcfg.reset_cfg[3] ^ pcfg.reset_cfg[1]))
    else $error("reset pin wrong on floating kick");
  a_lock_freeze: assert property (valid && pcfg.locked |-> cfg_out == pcfg)
    else $error("configuration moved while locked");
  a_cfg_quiet: assert property (valid && cfg_out != pcfg |-> !scl_in)
    else $error("configuration moved outside clock low");
  a_ack_low: assert property ($rose(sda_oe) |-> !scl_in [*2])
    else $error("data drive began with clock high");
  a_oe_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe) && !sda_out)
    else $error("data drive moved while clock high");
endmodule

bind scr_regs scr_regs_checker u_scr_regs_checker (
  .clock(clock), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .causes(causes), .cfg_out(cfg_out), .reset_out(reset_out)
);
`default_nettype wire

// [sim/scr_regs_test.sv]
// scr_regs_test.sv - self-checking bench for the supervisor config bank
`timescale 1ns/1ps
`default_nettype none
`include "scr_cfg.svh"

module scr_regs_test;
  import scr_pkg::*;

  typedef struct packed {
    logic [7:0] off;
    logic [7:0] wdat;
    logic [7:0] rdat;
  } scr_row_t;

  localparam int LIMIT = 40000;  // run needs about half of this
  localparam logic [3:0] CFGS [4] = '{4'hF, 4'h0, 4'h5, 4'hA};  // each option bit both ways
  // write all ones, expect only the stored bits back; 0x08 and 0x10 lie outside the bank
  scr_row_t rows [9] = '{'{8'h09, 8'hFF, 8'h07}, '{8'h0A, 8'hFF, 8'h07}, '{8'h0B, 8'hFF, 8'h07},
    '{8'h0C, 8'hFF, 8'h07}, '{8'h0D, 8'hFF, 8'h0F}, '{8'h0E, 8'hFF, 8'h08}, '{8'h0F, 8'hFF, 8'h08},
    '{8'h08, 8'hFF, 8'h00}, '{8'h10, 8'hFF, 8'h00}};

  logic        clock = 1'b0;
  logic        rst_b;
  logic        scl;
  logic        sda_pull;
  wire         sda_line;
  logic        sda_out;
  logic        sda_oe;
  scr_causes_t causes;
  scr_regs_t   cfg;
  logic        reset_out;
  logic [7:0]  rd;
  logic        ack;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;

  // open-drain wire with pull-up: low if either side pulls
  assign sda_line = ~sda_pull & ~(sda_oe & ~sda_out);

  always #4 clock = ~clock;

  scr_regs u_scr_regs (.clock(clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .causes(causes), .cfg_out(cfg), .reset_out(reset_out));
  scr_host u_scr_host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  // wide enough for the whole configuration word; narrower values are zero-extended
  task automatic chk(input string what, input logic [$bits(scr_regs_t)-1:0] seen,
                     input logic [$bits(scr_regs_t)-1:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // reset pin level worked out from the options and one cause set
  function automatic logic exp_rst(input logic [3:0] c, input scr_causes_t s);
    logic a;
    a = s.other_cause | (s.shutdown_active & ~c[0]) | (s.fourth_under & ~c[2]) | (s.kick_floating & c[3]);
    return c[1] ? a : ~a;
  endfunction

  // start, write address, pointer byte
  task automatic frame(input logic [7:0] off);
    u_scr_host.start();
    u_scr_host.byte_io({`SCR_DEV_ADDR, 1'b0}, 1'b1, rd, ack);
    chk("addr ack", ack, 1'b0);
    u_scr_host.byte_io(off, 1'b1, rd, ack);
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    frame(off);
    u_scr_host.byte_io(d, 1'b1, rd, ack);
    u_scr_host.stop();
  endtask

  // pointer write, repeated start, one byte read and refused
  task automatic rdchk(input string what, input logic [7:0] off, input logic [7:0] exp);
    frame(off);
    u_scr_host.start();
    u_scr_host.byte_io({`SCR_DEV_ADDR, 1'b1}, 1'b1, rd, ack);
    u_scr_host.byte_io(8'hFF, 1'b1, rd, ack);
    u_scr_host.stop();
    chk(what, rd, exp);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    rst_b  = 1'b0;
    causes = '0;
    repeat (6) @(negedge clock);
    rst_b = 1'b1;
    chk("cfg at reset", cfg, '0);
    repeat (3) @(negedge clock);
    foreach (rows[i]) begin
      rdchk("reset value", rows[i].off, 8'h00);
      wr(rows[i].off, rows[i].wdat);
      rdchk("read back", rows[i].off, rows[i].rdat);
    end
    chk("cfg fields", cfg, 19'h7FFFE);
    $display("test rows done");
    // each of the four listed option patterns against each single cause
    foreach (CFGS[j]) begin
      wr(8'h0D, {4'h0, CFGS[j]});
      for (int k = 0; k < 4; k++) begin
        causes = scr_causes_t'(4'h1 << k);
        repeat (2) @(negedge clock);
        chk("reset pin", reset_out, exp_rst(CFGS[j], causes));
      end
      causes = '0;
    end
    $display("test reset pin done");
    // burst write: pointer steps after each data byte
    frame(8'h09);
    u_scr_host.byte_io(8'h03, 1'b1, rd, ack);
    chk("burst ack 0", ack, 1'b0);
    u_scr_host.byte_io(8'h05, 1'b1, rd, ack);
    chk("burst ack 1", ack, 1'b0);
    u_scr_host.stop();
    // burst read: host acknowledges the first byte to get the second
    frame(8'h09);
    u_scr_host.start();
    u_scr_host.byte_io({`SCR_DEV_ADDR, 1'b1}, 1'b1, rd, ack);
    chk("read addr ack", ack, 1'b0);
    u_scr_host.byte_io(8'hFF, 1'b0, rd, ack);
    chk("burst rd 0", rd, 8'h03);
    u_scr_host.byte_io(8'hFF, 1'b1, rd, ack);
    u_scr_host.stop();
    chk("burst rd 1", rd, 8'h05);
    // another slave's address: no acknowledge and no write
    u_scr_host.start();
    u_scr_host.byte_io({~`SCR_DEV_ADDR, 1'b0}, 1'b1, rd, ack);
    chk("foreign addr nack", ack, 1'b1);
    u_scr_host.byte_io(8'h09, 1'b1, rd, ack);
    u_scr_host.byte_io(8'h00, 1'b1, rd, ack);
    u_scr_host.stop();
    chk("foreign write dropped", cfg.turn_on_hold_time, 3'h3);
    $display("test burst done");
    wr(8'h15, 8'h01);
    rdchk("lock", 8'h15, 8'h01);
    wr(8'h09, 8'h02);
    rdchk("locked hold", 8'h09, 8'h03);
    chk("lock bit", cfg.locked, 1'b1);
    $display("test lock done");
    // second reset mid-run clears everything, lock too
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    chk("cfg in reset", cfg, '0);
    rst_b = 1'b1;
    repeat (3) @(negedge clock);
    rdchk("lock after reset", 8'h15, 8'h00);
    $display("test reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
